// File: test/sep_mul_partner.sv
`timescale 1ns/1ps

// multiplier side: ends a long multiply or stays busy on request
module sep_mul_partner (
	input  wire clk,
	input  wire rst,
	input  wire start,
	input  wire hold,
	output reg  dmul_ma_end,
	output reg  mult_busy_ext
);
	// registered so requests land one edge after the bench asks
	always @(posedge clk) begin
		dmul_ma_end <= !rst && start;
		mult_busy_ext <= !rst && hold;
	end
endmodule

// File: test/sep_pipe_seq_properties.sv
`timescale 1ns/1ps
`include "sep_consts.vh"

// sees only the sequencer ports
module sep_pipe_seq_properties (
	input wire       clk,
	input wire       rst,
	input wire       op_valid,
	input wire [3:0] op_class,
	input wire       op_undefined,
	input wire       op_pc_write,
	input wire       op_two_overrun,
	input wire       branch_delay_slot,
	input wire       irq_req,
	input wire       addr_err_req,
	input wire       dmul_ma_end,
	input wire       mult_busy_ext,
	input wire       wake,
	input wire       decode_ready,
	input wire       execute_stage,
	input wire       memory_access_stage,
	input wire       mem_access,
	input wire       mult_access,
	input wire       fetch_blocked,
	input wire       write_back_stage,
	input wire       target_fetch,
	input wire [1:0] discard_fetches,
	input wire [2:0] exc_kind,
	input wire       sleep_mode,
	input wire       multiplier_busy_phase
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// irq and address error share one sequence
	wire ten_seq = exc_kind == `SEP_EXC_IRQ || exc_kind == `SEP_EXC_ADDR;
	wire ill_seq = exc_kind == `SEP_EXC_ILL || exc_kind == `SEP_EXC_SLOT;

	chk_mul_tail: assert property (dmul_ma_end |=> multiplier_busy_phase [*4])
		else $error("multiplier busy tail too short");
	chk_wb_order: assert property (write_back_stage |-> $past(memory_access_stage))
		else $error("write-back without access before it");
	chk_mac_blocks: assert property (mult_access |-> memory_access_stage && fetch_blocked)
		else $error("multiplier access not contending fetch");
	chk_stall_hold: assert property (mult_access && multiplier_busy_phase |=> mult_access)
		else $error("access stage not extended while busy");
	chk_trap_target: assert property (exc_kind == `SEP_EXC_TRAP |-> discard_fetches == 2'h2 ##6 target_fetch)
		else $error("trap target fetch misplaced");
	chk_exc_target: assert property (ten_seq |-> discard_fetches == 2'h1 ##7 target_fetch)
		else $error("exception target fetch misplaced");
	chk_exc_hold: assert property (ten_seq |-> !decode_ready [*8])
		else $error("decode reopened inside exception sequence");
	chk_ill_target: assert property (ill_seq |-> ##6 target_fetch)
		else $error("illegal target fetch misplaced");
	chk_sleep_shut: assert property ($rose(sleep_mode) |-> !decode_ready)
		else $error("decode open on entering sleep");

	cover property (target_fetch);
	cover property (mult_access && multiplier_busy_phase);
	cover property (exc_kind == `SEP_EXC_SLOT);
endmodule

bind sep_pipe_seq sep_pipe_seq_properties chk (.clk(clk), .rst(rst), .op_valid(op_valid),
	.op_class(op_class), .op_undefined(op_undefined), .op_pc_write(op_pc_write),
	.op_two_overrun(op_two_overrun), .branch_delay_slot(branch_delay_slot), .irq_req(irq_req),
	.addr_err_req(addr_err_req), .dmul_ma_end(dmul_ma_end), .mult_busy_ext(mult_busy_ext),
	.wake(wake), .decode_ready(decode_ready), .execute_stage(execute_stage),
	.memory_access_stage(memory_access_stage), .mem_access(mem_access), .mult_access(mult_access),
	.fetch_blocked(fetch_blocked), .write_back_stage(write_back_stage), .target_fetch(target_fetch),
	.discard_fetches(discard_fetches), .exc_kind(exc_kind), .sleep_mode(sleep_mode),
	.multiplier_busy_phase(multiplier_busy_phase));

// File: test/sep_pipe_seq_tb.sv
`timescale 1ns/1ps
`include "sep_consts.vh"

module sep_pipe_seq_tb;
	reg        clk, rst, op_valid, op_undefined, op_pc_write, op_two_overrun;
	reg        branch_delay_slot, irq_req, addr_err_req, wake, mstart, mhold;
	reg  [3:0] op_class;
	wire       decode_ready, execute_stage, memory_access_stage, mem_access, mult_access;
	wire       fetch_blocked, write_back_stage, target_fetch, sleep_mode, multiplier_busy_phase;
	wire       dmul_ma_end, mult_busy_ext;
	wire [1:0] discard_fetches;
	wire [2:0] exc_kind;
	integer    mismatches, n_tests;

	sep_pipe_seq dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_class(op_class),
		.op_undefined(op_undefined), .op_pc_write(op_pc_write), .op_two_overrun(op_two_overrun),
		.branch_delay_slot(branch_delay_slot), .irq_req(irq_req), .addr_err_req(addr_err_req),
		.dmul_ma_end(dmul_ma_end), .mult_busy_ext(mult_busy_ext), .wake(wake),
		.decode_ready(decode_ready), .execute_stage(execute_stage),
		.memory_access_stage(memory_access_stage), .mem_access(mem_access), .mult_access(mult_access),
		.fetch_blocked(fetch_blocked), .write_back_stage(write_back_stage), .target_fetch(target_fetch),
		.discard_fetches(discard_fetches), .exc_kind(exc_kind), .sleep_mode(sleep_mode),
		.multiplier_busy_phase(multiplier_busy_phase));

	sep_mul_partner mul (.clk(clk), .rst(rst), .start(mstart), .hold(mhold),
		.dmul_ma_end(dmul_ma_end), .mult_busy_ext(mult_busy_ext));

	// one slot of stage flags, ready in the low bit
	wire [7:0] slot = {execute_stage, memory_access_stage, mem_access, mult_access,
		fetch_blocked, write_back_stage, target_fetch, decode_ready};

	task cmp(input string s, input [63:0] e, input [63:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED %s expected %h seen %h", s, e, g);
			end
		end
	endtask

	// waits for an open, unstalled decode slot, offers one request
	task go(input [5:0] m, input [3:0] c);
		integer i;
		begin
			for (i = 0; i < 30 && !(decode_ready === 1'b1 && !(mult_access && multiplier_busy_phase)); i = i + 1)
				@(negedge clk);
			cmp("decode wait", 1, i < 30);
			{op_two_overrun, branch_delay_slot, op_pc_write, op_undefined, addr_err_req, irq_req} = m;
			op_valid = 1'b1;
			op_class = c;
			@(negedge clk);
			{op_two_overrun, branch_delay_slot, op_pc_write, op_undefined, addr_err_req, irq_req} = 6'h00;
			op_valid = 1'b0;
		end
	endtask

	// eight slots compared against a packed schedule
	task run(input string s, input [5:0] m, input [3:0] c, input [63:0] e, input [4:0] kd);
		integer i;
		begin
			go(m, c);
			cmp(s, kd, {exc_kind, discard_fetches});
			for (i = 0; i < 8; i = i + 1) begin
				cmp(s, e[63-8*i -: 8], slot);
				@(negedge clk);
			end
			repeat (4) @(negedge clk);
		end
	endtask

	task t_plain;
		begin
			run("alu", 6'h00, `SEP_CLS_ALU, 64'h81_01_01_01_01_01_01_01, 5'h00);
			run("creg ld", 6'h00, `SEP_CLS_CREG_LD, 64'h80_68_81_01_01_01_01_01, 5'h00);
			run("creg st", 6'h00, `SEP_CLS_CREG_ST, 64'h80_69_01_01_01_01_01_01, 5'h00);
			run("pr ld", 6'h00, `SEP_CLS_PR_LD, 64'h81_69_05_01_01_01_01_01, 5'h00);
			run("pr st", 6'h00, `SEP_CLS_PR_ST, 64'h81_69_01_01_01_01_01_01, 5'h00);
		end
	endtask

	task t_mac;
		begin
			run("reg mac", 6'h00, `SEP_CLS_REG_MAC, 64'h81_59_01_01_01_01_01_01, 5'h00);
			run("mem mac", 6'h00, `SEP_CLS_MEM_MAC, 64'h81_79_01_01_01_01_01_01, 5'h00);
			run("mac reg", 6'h00, `SEP_CLS_MAC_REG, 64'h81_59_05_01_01_01_01_01, 5'h00);
			run("mac mem", 6'h00, `SEP_CLS_MAC_MEM, 64'h81_79_01_01_01_01_01_01, 5'h00);
		end
	endtask

	task t_branch;
		begin
			run("rte", 6'h00, `SEP_CLS_RTE, 64'h80_60_60_03_01_01_01_01, 5'h00);
			run("rte slot", 6'h04, `SEP_CLS_ILL, 64'h80_80_60_60_60_80_82_01, 5'h11);
			run("trap", 6'h00, `SEP_CLS_TRAP, 64'h80_80_60_60_60_80_82_01, 5'h16);
		end
	endtask

	// every exception source but trap, plus two simultaneous
	task t_exc;
		begin
			run("irq", 6'h01, `SEP_CLS_ALU, 64'h80_80_60_60_80_60_80_82, 5'h05);
			run("addr", 6'h02, `SEP_CLS_ALU, 64'h80_80_60_60_80_60_80_82, 5'h09);
			run("addr irq", 6'h03, `SEP_CLS_ALU, 64'h80_80_60_60_80_60_80_82, 5'h09);
			run("ill", 6'h04, `SEP_CLS_ILL, 64'h80_80_60_60_60_80_82_01, 5'h0d);
			run("ill two", 6'h24, `SEP_CLS_ILL, 64'h80_80_60_60_60_80_82_01, 5'h0e);
			run("slot und", 6'h14, `SEP_CLS_ILL, 64'h80_80_60_60_60_80_82_01, 5'h11);
			run("slot pc", 6'h18, `SEP_CLS_ALU, 64'h80_80_60_60_60_80_82_01, 5'h11);
		end
	endtask

	task t_mul;
		integer i, n;
		begin
			mstart = 1'b1;
			@(negedge clk);
			mstart = 1'b0;
			n = 0;
			for (i = 0; i < 8; i = i + 1) begin
				@(negedge clk);
				n = n + (multiplier_busy_phase === 1'b1);
			end
			cmp("busy tail", 4, n);
		end
	endtask

	// busy multiplier, from a multiply tail then from outside
	task t_stall;
		integer k, i, n;
		begin
			for (k = 0; k < 2; k = k + 1) begin
				mstart = (k == 0);
				mhold = (k == 1);
				@(negedge clk);
				mstart = 1'b0;
				go(6'h00, `SEP_CLS_REG_MAC);
				n = 0;
				for (i = 0; i < 10; i = i + 1) begin
					if (i == 3)
						mhold = 1'b0;
					n = n + (mult_access === 1'b1);
					@(negedge clk);
				end
				cmp("stall", k ? 5 : 4, n);
			end
		end
	endtask

	task t_sleep;
		begin
			go(6'h00, `SEP_CLS_SLEEP);
			cmp("sleep ex", 1, execute_stage);
			repeat (3) @(negedge clk);
			cmp("asleep", 2'b10, {sleep_mode, decode_ready});
			wake = 1'b1;
			@(negedge clk);
			wake = 1'b0;
			cmp("awake", 2'b01, {sleep_mode, decode_ready});
		end
	endtask

	task results;
		begin
			if (mismatches == 0 && n_tests > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// watchdog, well past the few hundred cycles needed
	initial begin
		#200000;
		mismatches = mismatches + 1;
		results;
	end

	initial begin
		{op_valid, op_undefined, op_pc_write, op_two_overrun, branch_delay_slot} = 5'h00;
		{irq_req, addr_err_req, wake, mstart, mhold} = 5'h00;
		op_class = 4'h0;
		mismatches = 0;
		n_tests = 0;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		cmp("reset", 0, decode_ready);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_plain;
		t_mac;
		t_branch;
		t_exc;
		t_mul;
		t_stall;
		t_sleep;
		results;
	end
endmodule

// File: verilog/sep_consts.vh
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH

// instruction classes presented at decode
`define SEP_CLS_W        4
`define SEP_CLS_ALU      4'h0
`define SEP_CLS_CREG_LD  4'h1
`define SEP_CLS_CREG_ST  4'h2
`define SEP_CLS_PR_LD    4'h3
`define SEP_CLS_PR_ST    4'h4
`define SEP_CLS_REG_MAC  4'h5
`define SEP_CLS_MEM_MAC  4'h6
`define SEP_CLS_MAC_REG  4'h7
`define SEP_CLS_MAC_MEM  4'h8
`define SEP_CLS_RTE      4'h9
`define SEP_CLS_TRAP     4'ha
`define SEP_CLS_SLEEP    4'hb
`define SEP_CLS_EXC      4'hc
`define SEP_CLS_ILL      4'hd

// exception kinds reported on acceptance
`define SEP_EXC_NONE     3'h0
`define SEP_EXC_IRQ      3'h1
`define SEP_EXC_ADDR     3'h2
`define SEP_EXC_ILL      3'h3
`define SEP_EXC_SLOT     3'h4
`define SEP_EXC_TRAP     3'h5

// cycles after the last multiplier stage of a double-length multiply
`define SEP_MUL_TAIL     3'h4

// decode holds, in slots
`define SEP_HOLD_W       4
`define SEP_HOLD_CREG_LD 4'h2
`define SEP_HOLD_CREG_ST 4'h1
`define SEP_HOLD_RTE     4'h3
`define SEP_HOLD_NINE    4'h7
`define SEP_HOLD_TEN     4'h8

`endif

// File: verilog/sep_mul_busy.v
`timescale 1ns/1ps
`include "sep_consts.vh"

module sep_mul_busy (
	input  wire       clk,
	input  wire       rst,
	input  wire       dmul_ma_end,
	input  wire       mult_busy_ext,
	output reg        multiplier_busy_phase
);
	reg  [2:0] cnt;
	reg  [2:0] next_cnt;

	// tail counts every cycle, not every slot, so decode stalls do not stretch it
	always @* begin
		if (dmul_ma_end)
			next_cnt = `SEP_MUL_TAIL;
		else if (cnt != 3'h0)
			next_cnt = cnt - 3'h1;
		else
			next_cnt = 3'h0;
	end

	always @(posedge clk) begin
		if (rst) begin
			cnt                   <= 3'h0;
			multiplier_busy_phase <= 1'b0;
		end else begin
			cnt                   <= next_cnt;
			multiplier_busy_phase <= (next_cnt != 3'h0) | mult_busy_ext;
		end
	end
endmodule

// File: verilog/sep_pipe_seq.v
// Function
// - system ALU ops: fetch, decode, execute only
// - control load: five stages, decode held two
// - control store: four stages, decode held one
// - return-register load: ordinary load with write-back
// - return-register store: four stages, no hold
// - register-to-accumulator: multiplier access contending fetch
// - memory-to-accumulator: memory and multiplier, contends
// - accumulator-to-register: five stages, multiplier, contends
// - accumulator-to-memory: memory and multiplier, contends
// - busy multiplier extends accumulator access stage
// - multiplier busy four cycles after multiply
// - exception return: two non-contending accesses, hold three
// - return target fetched after final access
// - software trap: nine stages, discard two fetches
// - trap target fetched at ninth stage
// - power-down: three stages, then sleep
// - interrupt at decode: ten-stage replacement sequence
// - interrupt: one overrun fetch, target at end
// - address error at decode: same ten stages
// - address error: overrun fetch, target at end
// - illegal instruction: nine-stage replacement sequence
// - illegal: one or two overrun fetches
// - delay-slot undefined or branch: illegal-slot exception
`timescale 1ns/1ps
`include "sep_consts.vh"

module sep_pipe_seq (
	input  wire                  clk,
	input  wire                  rst,
	// decode slot contents
	input  wire                  op_valid,
	input  wire [`SEP_CLS_W-1:0] op_class,
	input  wire                  op_undefined,
	input  wire                  op_pc_write,
	input  wire                  op_two_overrun,
	input  wire                  branch_delay_slot,
	// exception requests, held by the source until a decode slot opens
	input  wire                  irq_req,
	input  wire                  addr_err_req,
	// multiplier side
	input  wire                  dmul_ma_end,
	input  wire                  mult_busy_ext,
	// power state
	input  wire                  wake,
	// per-slot stage flags, all registered
	output reg                   decode_ready,
	output reg                   execute_stage,
	output reg                   memory_access_stage,
	output reg                   mem_access,
	output reg                   mult_access,
	output reg                   fetch_blocked,
	output reg                   write_back_stage,
	output reg                   target_fetch,
	// one-slot exception report and power state
	output reg  [1:0]            discard_fetches,
	output reg  [2:0]            exc_kind,
	output reg                   sleep_mode,
	output wire                  multiplier_busy_phase
);
	// each vector is a future schedule; bit 0 is the current slot
	reg  [7:0]             sched_ex;
	reg  [7:0]             sched_ma;
	reg  [7:0]             sched_mem;
	reg  [7:0]             sched_mul;
	reg  [7:0]             sched_cont;
	reg  [7:0]             sched_wb;
	reg  [7:0]             sched_tgt;
	// decode gate and delay-slot bookkeeping
	reg  [`SEP_HOLD_W-1:0] hold_cnt;
	reg                    in_rte_slot;
	reg                    sleep_pending;

	// combinational next values
	reg  [`SEP_CLS_W-1:0]  eff_class;
	reg  [2:0]             next_kind;
	reg  [1:0]             next_discard;
	reg  [`SEP_HOLD_W-1:0] next_hold;
	reg                    next_ready;
	reg  [7:0]             next_exec;
	reg  [7:0]             next_access;
	reg  [7:0]             next_mem;
	reg  [7:0]             next_mul;
	reg  [7:0]             next_cont;
	reg  [7:0]             next_wback;
	reg  [7:0]             next_tgt;

	// stage table lookups for the class in decode
	wire [7:0]             rom_ex;
	wire [7:0]             rom_ma;
	wire [7:0]             rom_mem;
	wire [7:0]             rom_mul;
	wire [7:0]             rom_cont;
	wire [7:0]             rom_wb;
	wire [7:0]             rom_tgt;
	wire [`SEP_HOLD_W-1:0] rom_hold;
	// decode slot handshake
	wire                   accept;
	wire                   stall;
	wire                   in_slot;
	wire                   ready_now;

	// per-class stage table; a pure lookup, no state
	sep_stage_rom u_rom (
		.cls      (eff_class),
		.ex_pat   (rom_ex),
		.ma_pat   (rom_ma),
		.mem_pat  (rom_mem),
		.mul_pat  (rom_mul),
		.cont_pat (rom_cont),
		.wb_pat   (rom_wb),
		.tgt_pat  (rom_tgt),
		.hold     (rom_hold)
	);

	// the busy tail counts cycles, not slots, so it lives apart from the schedule
	sep_mul_busy u_mul (
		.clk                   (clk),
		.rst                   (rst),
		.dmul_ma_end           (dmul_ma_end),
		.mult_busy_ext         (mult_busy_ext),
		.multiplier_busy_phase (multiplier_busy_phase)
	);

	// an accumulator access that meets a busy multiplier freezes the whole schedule;
	// freezing everything, not just the access, keeps the extended stage one slot
	// long and keeps the later stages of overlapped instructions in step;
	// the cost is that unrelated overlapped stages wait as well
	assign stall     = sched_mul[0] & multiplier_busy_phase;
	assign ready_now = decode_ready & ~stall;
	// delay slots come from outside, except the one after our own exception return
	assign in_slot   = branch_delay_slot | in_rte_slot;
	// exceptions are taken in the decode slot, so they need a decode opportunity too
	assign accept    = ready_now & (op_valid | irq_req | addr_err_req);

	// what the decode slot turns into: address error first, then interrupt,
	// then instruction-caused exceptions, then the instruction itself;
	// limitation: a trap in a delay slot counts as illegal only via op_pc_write,
	// so the instruction decoder must flag it
	always @* begin
		eff_class    = op_class;
		next_kind    = `SEP_EXC_NONE;
		next_discard = 2'h0;
		if (addr_err_req) begin
			eff_class    = `SEP_CLS_EXC;
			next_kind    = `SEP_EXC_ADDR;
			next_discard = 2'h1;
		end else if (irq_req) begin
			eff_class    = `SEP_CLS_EXC;
			next_kind    = `SEP_EXC_IRQ;
			next_discard = 2'h1;
		end else if (in_slot & (op_undefined | op_pc_write)) begin
			eff_class    = `SEP_CLS_ILL;
			next_kind    = `SEP_EXC_SLOT;
			next_discard = op_two_overrun ? 2'h2 : 2'h1;
		end else if (op_undefined) begin
			eff_class    = `SEP_CLS_ILL;
			next_kind    = `SEP_EXC_ILL;
			next_discard = op_two_overrun ? 2'h2 : 2'h1;
		end else if (op_class == `SEP_CLS_TRAP) begin
			next_kind    = `SEP_EXC_TRAP;
			next_discard = 2'h2;
		end
	end

	// decode hold counts slots; a frozen slot does not count
	// hold width caps the longest decode gap at fifteen slots
	always @* begin
		if (stall)
			next_hold = hold_cnt;
		else if (accept)
			next_hold = rom_hold;
		else if (hold_cnt != 4'h0)
			next_hold = hold_cnt - 4'h1;
		else
			next_hold = 4'h0;
	end

	// next schedule: shift one slot and merge the newly decoded sequence
	always @* begin
		next_exec   = (sched_ex >> 1) | (accept ? rom_ex : 8'h00);
		next_access = (sched_ma >> 1) | (accept ? rom_ma : 8'h00);
		next_mem    = (sched_mem >> 1) | (accept ? rom_mem : 8'h00);
		next_mul    = (sched_mul >> 1) | (accept ? rom_mul : 8'h00);
		next_cont   = (sched_cont >> 1) | (accept ? rom_cont : 8'h00);
		next_wback  = (sched_wb >> 1) | (accept ? rom_wb : 8'h00);
		next_tgt    = (sched_tgt >> 1) | (accept ? rom_tgt : 8'h00);
	end

	// schedule advance; a frozen slot keeps every vector as it is
	always @(posedge clk) begin
		if (rst) begin
			sched_ex   <= 8'h00;
			sched_ma   <= 8'h00;
			sched_mem  <= 8'h00;
			sched_mul  <= 8'h00;
			sched_cont <= 8'h00;
			sched_wb   <= 8'h00;
			sched_tgt  <= 8'h00;
		end else if (!stall) begin
			sched_ex   <= next_exec;
			sched_ma   <= next_access;
			sched_mem  <= next_mem;
			sched_mul  <= next_mul;
			sched_cont <= next_cont;
			sched_wb   <= next_wback;
			sched_tgt  <= next_tgt;
		end
	end

	// stage outputs mirror the next current slot so they come from flops;
	// they freeze with the schedule, so an extended access reads as one long slot
	always @(posedge clk) begin
		if (rst) begin
			execute_stage       <= 1'b0;
			memory_access_stage <= 1'b0;
			mem_access          <= 1'b0;
			mult_access         <= 1'b0;
			fetch_blocked       <= 1'b0;
			write_back_stage    <= 1'b0;
			target_fetch        <= 1'b0;
		end else if (!stall) begin
			execute_stage       <= next_exec[0];
			memory_access_stage <= next_access[0];
			mem_access          <= next_mem[0];
			mult_access         <= next_mul[0];
			fetch_blocked       <= next_cont[0];
			write_back_stage    <= next_wback[0];
			target_fetch        <= next_tgt[0];
		end
	end

	// exception report: a one-slot pulse on acceptance, none otherwise
	always @(posedge clk) begin
		if (rst)
			exc_kind <= `SEP_EXC_NONE;
		else if (accept)
			exc_kind <= next_kind;
		else
			exc_kind <= `SEP_EXC_NONE;
	end

	// fetches the front end must drop; it cannot see the sequence itself
	always @(posedge clk) begin
		if (rst)
			discard_fetches <= 2'h0;
		else if (accept)
			discard_fetches <= next_discard;
		else
			discard_fetches <= 2'h0;
	end

	// the instruction after an exception return sits in its delay slot
	always @(posedge clk) begin
		if (rst)
			in_rte_slot <= 1'b0;
		else if (accept)
			in_rte_slot <= (eff_class == `SEP_CLS_RTE);
	end

	// power-down issued; marks the execute slot before sleep begins
	always @(posedge clk) begin
		if (rst)
			sleep_pending <= 1'b0;
		else if (accept && eff_class == `SEP_CLS_SLEEP)
			sleep_pending <= 1'b1;
		else
			sleep_pending <= 1'b0;
	end

	// sleep is entered after the execute slot; wake wins only once asleep,
	// so a wake during the execute slot is ignored and must be held
	always @(posedge clk) begin
		if (rst)
			sleep_mode <= 1'b0;
		else if (sleep_pending)
			sleep_mode <= 1'b1;
		else if (wake)
			sleep_mode <= 1'b0;
	end

	// decode reopens when the hold is spent and the power-down path lets go;
	// the power-down keeps the next instruction from issuing until wake
	always @* begin
		next_ready = (next_hold == 4'h0)
			& ~(accept & (eff_class == `SEP_CLS_SLEEP))
			& ~sleep_pending
			& ~(sleep_mode & ~wake);
	end

	// decode gate: hold counter and the registered ready
	always @(posedge clk) begin
		if (rst) begin
			hold_cnt     <= 4'h0;
			decode_ready <= 1'b0;
		end else begin
			hold_cnt     <= next_hold;
			decode_ready <= next_ready;
		end
	end
endmodule

// File: verilog/sep_stage_rom.v
`timescale 1ns/1ps
`include "sep_consts.vh"

// bit i of each pattern is the slot i+1 after the decode slot
module sep_stage_rom (
	input  wire [`SEP_CLS_W-1:0]  cls,
	output reg  [7:0]             ex_pat,
	output reg  [7:0]             ma_pat,
	output reg  [7:0]             mem_pat,
	output reg  [7:0]             mul_pat,
	output reg  [7:0]             cont_pat,
	output reg  [7:0]             wb_pat,
	output reg  [7:0]             tgt_pat,
	output reg  [`SEP_HOLD_W-1:0] hold
);
	always @* begin
		ex_pat  = 8'h01;
		ma_pat  = 8'h00;
		mem_pat = 8'h00;
		mul_pat = 8'h00;
		wb_pat  = 8'h00;
		tgt_pat = 8'h00;
		hold    = 4'h0;
		case (cls)
			`SEP_CLS_ALU, `SEP_CLS_SLEEP: begin
				ex_pat = 8'h01;
			end
			`SEP_CLS_CREG_LD: begin
				ex_pat  = 8'h05;
				ma_pat  = 8'h02;
				mem_pat = 8'h02;
				hold    = `SEP_HOLD_CREG_LD;
			end
			`SEP_CLS_CREG_ST: begin
				ma_pat  = 8'h02;
				mem_pat = 8'h02;
				hold    = `SEP_HOLD_CREG_ST;
			end
			`SEP_CLS_PR_LD: begin
				ma_pat  = 8'h02;
				mem_pat = 8'h02;
				wb_pat  = 8'h04;
			end
			`SEP_CLS_PR_ST: begin
				ma_pat  = 8'h02;
				mem_pat = 8'h02;
			end
			`SEP_CLS_REG_MAC: begin
				ma_pat  = 8'h02;
				mul_pat = 8'h02;
			end
			`SEP_CLS_MEM_MAC, `SEP_CLS_MAC_MEM: begin
				ma_pat  = 8'h02;
				mem_pat = 8'h02;
				mul_pat = 8'h02;
			end
			`SEP_CLS_MAC_REG: begin
				ma_pat  = 8'h02;
				mul_pat = 8'h02;
				wb_pat  = 8'h04;
			end
			`SEP_CLS_RTE: begin
				ma_pat  = 8'h06;
				mem_pat = 8'h06;
				tgt_pat = 8'h08;
				hold    = `SEP_HOLD_RTE;
			end
			`SEP_CLS_TRAP, `SEP_CLS_ILL: begin
				ex_pat  = 8'h63;
				ma_pat  = 8'h1c;
				mem_pat = 8'h1c;
				tgt_pat = 8'h40;
				hold    = `SEP_HOLD_NINE;
			end
			`SEP_CLS_EXC: begin
				ex_pat  = 8'hd3;
				ma_pat  = 8'h2c;
				mem_pat = 8'h2c;
				tgt_pat = 8'h80;
				hold    = `SEP_HOLD_TEN;
			end
			default: begin
				ex_pat = 8'h01;
			end
		endcase
		// memory and multiplier accesses fight with fetch; return and exception sequences own the bus
		cont_pat = (cls == `SEP_CLS_RTE || cls >= `SEP_CLS_TRAP) ? 8'h00 : ma_pat;
	end
endmodule
